// File: scp_serial_port.sv
/*
  slave serial control port with its own byte register file.
  assumes sclk_i, cs_b_i and sdio_i come from the host, that the serial clock
  stands still while chip select is high, and that the configuration inputs
  settle two serial clock edges before a frame; the core side runs on mclk_i.
*/
// What this block does
// - four-wire mode: data-in/out carries host bits, data-out carries device bits.
// - three-wire mode: shared line carries both directions, data-out stays off.
// - outputs change on falling clock edge, inputs captured on rising edge.
// - both data pins float whenever chip select is high; no pulls inside.
// - slave only; each frame starts with a 16-bit instruction.
// - instruction phase then data phase; instruction picks direction and address.
// - instruction bit 15 high means read, low means write.
// - instruction bits 14 to 0 give the starting byte address.
// - all addresses valid; undefined writes dropped, undefined reads give zero.
// - streaming off: exactly one data byte follows the instruction.
// - lsb-first: address lsb first, then direction bit; data lsb first.
// - msb-first: direction bit first, address msb first; data msb first.
// - streaming on: bytes keep flowing while chip select stays low.
// - stepping up, address increments per byte; past the last it wraps to zero.
// - stepping down, address decrements per byte; below zero it wraps to last.
// - streaming address changes only after the last bit of each byte.
// - clock and data lines are ignored while chip select is high.
// - raising chip select aborts; finished bytes stay, later ones are dropped.
// - every register is 8 bits wide.
`include "scp_regs.svh"
`default_nettype none

module scp_serial_port #(
  parameter int REG_COUNT = `SCP_REG_COUNT_DEF
) (
  // core clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // serial link
  input wire logic sclk_i,
  input wire logic cs_b_i,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe_o,
  output logic serial_data_out_o,
  output logic serial_data_out_oe_o,
  // static configuration
  input wire logic bit_order_select_i,
  input wire logic stream_transfer_enable_i,
  input wire logic address_step_direction_i,
  input wire logic separate_output_line_select_i,
  // core side write notice and busy flag
  output logic reg_write_o,
  output logic [`SCP_ADDR_W-1:0] reg_write_addr_o,
  output logic [`SCP_DATA_W-1:0] reg_write_data_o,
  output logic port_busy_o
);
  import scp_pkg::*;

  localparam int IW = (REG_COUNT > 2) ? $clog2(REG_COUNT) : 1;
  localparam logic [`SCP_ADDR_W-1:0] LAST_ADDR = `SCP_ADDR_W'(REG_COUNT - 1);

  // the byte index into the register file needs at least one bit
  generate
    if (REG_COUNT < 2 || REG_COUNT > 32768) begin : g_bad_count
      $error("scp_serial_port: REG_COUNT must lie between 2 and 32768");
    end
  endgenerate

  // ****************************************
  // link domain resets
  // ****************************************
  // protocol state is held in reset while chip select is high
  // the serial clock stands still outside frames, so chip select cannot pass a
  // synchroniser here; the host keeps a setup time before the first edge
  logic port_rst_b;
  assign port_rst_b = rst_b_i & ~cs_b_i;

  // ****************************************
  // configuration into the link domain
  // ****************************************
  logic [`SCP_CFG_W-1:0] cfg_s1;
  logic [`SCP_CFG_W-1:0] cfg_s2;
  logic [`SCP_CFG_W-1:0] cfg_pins;

  // gather the four static settings into one vector
  assign cfg_pins = {separate_output_line_select_i, address_step_direction_i,
                     stream_transfer_enable_i, bit_order_select_i};

  // these only advance while the serial clock runs, so a changed setting is
  // taken by a frame that starts at least two serial clock edges later
  always_ff @(posedge sclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_s1 <= '0;
      cfg_s2 <= '0;
    end else begin
      cfg_s1 <= cfg_pins;
      cfg_s2 <= cfg_s1;
    end
  end

  // ****************************************
  // register file
  // ****************************************
  // the registers live in the link domain; the core only hears of writes
  logic [`SCP_DATA_W-1:0] mem [REG_COUNT];
  logic mem_we;
  logic [`SCP_DATA_W-1:0] rd_byte;

  // ****************************************
  // receive side, rising edge
  // ****************************************
  scp_phase_t phase;
  scp_phase_t next_phase;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [`SCP_INSTR_BITS-1:0] instr;
  logic [`SCP_INSTR_BITS-1:0] next_instr;
  logic [`SCP_DATA_W-1:0] rx_byte;
  logic [`SCP_DATA_W-1:0] next_rx_byte;
  logic [`SCP_ADDR_W-1:0] addr;
  logic [`SCP_ADDR_W-1:0] next_addr;
  logic rd_mode;
  logic next_rd_mode;
  logic [`SCP_CFG_W-1:0] cfg;
  logic [`SCP_CFG_W-1:0] next_cfg;
  logic [`SCP_CFG_W-1:0] cur_cfg;
  logic addr_defined;

  // addresses at or past the register count are valid but hold nothing
  assign addr_defined = (int'(addr) < REG_COUNT);
  // undefined addresses read as zero
  assign rd_byte = addr_defined ? mem[addr[IW-1:0]] : '0;

  always_comb begin
    next_phase = phase;
    next_cnt = cnt;
    next_instr = instr;
    next_rx_byte = rx_byte;
    next_addr = addr;
    next_rd_mode = rd_mode;
    next_cfg = cfg;
    mem_we = 1'b0;
    // first bit of a frame uses the synchronised settings cfg_s2, later bits the latched copy in cfg
    cur_cfg = (phase == SCP_INSTR && cnt == 4'h0) ? cfg_s2 : cfg;
    unique case (phase)
      SCP_INSTR: begin
        next_cfg = cur_cfg;
        if (cur_cfg[`SCP_CFG_MSB]) begin
          next_instr = {instr[`SCP_INSTR_BITS-2:0], sdio_i};
        end else begin
          next_instr = {sdio_i, instr[`SCP_INSTR_BITS-1:1]};
        end
        next_cnt = cnt + 4'h1;
        if (cnt == `SCP_INSTR_LAST) begin
          next_phase = SCP_DATA;
          next_cnt = 4'h0;
          next_rd_mode = next_instr[`SCP_RW_BIT];
          next_addr = next_instr[`SCP_ADDR_W-1:0];
        end
      end
      SCP_DATA: begin
        if (cfg[`SCP_CFG_MSB]) begin
          next_rx_byte = {rx_byte[`SCP_DATA_W-2:0], sdio_i};
        end else begin
          next_rx_byte = {sdio_i, rx_byte[`SCP_DATA_W-1:1]};
        end
        next_cnt = cnt + 4'h1;
        if (cnt == `SCP_DATA_LAST) begin
          next_cnt = 4'h0;
          // only a byte that completes is committed
          mem_we = !rd_mode && addr_defined;
          if (!cfg[`SCP_CFG_STREAM]) begin
            next_phase = SCP_DONE;
          end else if (cfg[`SCP_CFG_UP]) begin
            // step only after the last bit of the byte
            // a start beyond the last register also steps to zero
            next_addr = (addr >= LAST_ADDR) ? `SCP_WRAP_ADDR : addr + 15'h1;
          end else begin
            next_addr = (addr == `SCP_WRAP_ADDR) ? LAST_ADDR : addr - 15'h1;
          end
        end
      end
      SCP_DONE: begin
        // streaming off: the rest of the frame is ignored until chip select rises
        next_cnt = cnt;
      end
    endcase
  end

  // chip select high holds this state in reset, which ends any frame
  always_ff @(posedge sclk_i or negedge port_rst_b) begin
    if (!port_rst_b) begin
      phase <= SCP_INSTR;
      cnt <= 4'h0;
      instr <= '0;
      rx_byte <= '0;
      addr <= '0;
      rd_mode <= 1'b0;
      cfg <= '0;
    end else begin
      phase <= next_phase;
      cnt <= next_cnt;
      instr <= next_instr;
      rx_byte <= next_rx_byte;
      addr <= next_addr;
      rd_mode <= next_rd_mode;
      cfg <= next_cfg;
    end
  end

  always_ff @(posedge sclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        mem[i] <= '0;
      end
    end else if (mem_we) begin
      mem[addr[IW-1:0]] <= next_rx_byte;
    end
  end

  // ****************************************
  // write notice toward the core domain
  // ****************************************
  // a toggle crosses to the core; address and data stand still for a byte time,
  // far longer than the core needs to settle the toggle
  logic hand_tgl;
  logic next_hand_tgl;
  logic [`SCP_ADDR_W-1:0] hand_addr;
  logic [`SCP_ADDR_W-1:0] next_hand_addr;
  logic [`SCP_DATA_W-1:0] hand_data;
  logic [`SCP_DATA_W-1:0] next_hand_data;

  always_comb begin
    next_hand_tgl = hand_tgl;
    next_hand_addr = hand_addr;
    next_hand_data = hand_data;
    if (mem_we) begin
      next_hand_tgl = ~hand_tgl;
      next_hand_addr = addr;
      next_hand_data = next_rx_byte;
    end
  end

  // only the core reset clears these, so a toggle outlives the end of a frame
  always_ff @(posedge sclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hand_tgl <= 1'b0;
      hand_addr <= '0;
      hand_data <= '0;
    end else begin
      hand_tgl <= next_hand_tgl;
      hand_addr <= next_hand_addr;
      hand_data <= next_hand_data;
    end
  end

  // ****************************************
  // transmit side, falling edge
  // ****************************************
  // launching on the falling edge gives the host half a period of setup
  // before it samples on the next rising edge
  logic tx_bit;
  logic next_tx_bit;
  logic tx_en;
  logic next_tx_en;

  always_comb begin
    // the output is enabled only through the data phase of a read
    next_tx_en = (phase == SCP_DATA) && rd_mode;
    // the bit index follows the count of data bits already taken
    if (cfg[`SCP_CFG_MSB]) begin
      next_tx_bit = rd_byte[3'h7 - cnt[2:0]];
    end else begin
      next_tx_bit = rd_byte[cnt[2:0]];
    end
  end

  always_ff @(negedge sclk_i or negedge port_rst_b) begin
    if (!port_rst_b) begin
      tx_bit <= 1'b0;
      tx_en <= 1'b0;
    end else begin
      tx_bit <= next_tx_bit;
      tx_en <= next_tx_en;
    end
  end

  assign sdio_o = tx_bit;
  assign serial_data_out_o = tx_bit;
  assign sdio_oe_o = tx_en & ~cfg[`SCP_CFG_FOUR];
  assign serial_data_out_oe_o = tx_en & cfg[`SCP_CFG_FOUR];

  // ****************************************
  // core domain
  // ****************************************
  logic tgl_s1;
  logic tgl_s2;
  logic tgl_s3;
  logic busy_s1;
  logic busy_s2;
  logic next_reg_write;
  logic [`SCP_ADDR_W-1:0] next_wr_addr;
  logic [`SCP_DATA_W-1:0] next_wr_data;

  // a notice pulses for one core cycle per completed write byte to a defined address
  always_comb begin
    next_reg_write = tgl_s2 ^ tgl_s3;
    next_wr_addr = reg_write_addr_o;
    next_wr_data = reg_write_data_o;
    if (tgl_s2 ^ tgl_s3) begin
      // the link holds these stable for at least a byte time
      next_wr_addr = hand_addr;
      next_wr_data = hand_data;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
      busy_s1 <= 1'b0;
      busy_s2 <= 1'b0;
      reg_write_o <= 1'b0;
      reg_write_addr_o <= '0;
      reg_write_data_o <= '0;
    end else begin
      tgl_s1 <= hand_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
      busy_s1 <= ~cs_b_i;
      busy_s2 <= busy_s1;
      reg_write_o <= next_reg_write;
      reg_write_addr_o <= next_wr_addr;
      reg_write_data_o <= next_wr_data;
    end
  end

  // busy follows chip select through two core flops
  assign port_busy_o = busy_s2;

endmodule : scp_serial_port

`default_nettype wire

// File: scp_regs.svh
/*
  constants of the serial control port: frame layout, field positions,
  and the serial clock limits that the host must keep.
  assumes nothing of its surroundings; definitions only.
*/
`ifndef SCP_REGS_SVH
`define SCP_REGS_SVH

// ****************************************
// frame layout
// ****************************************
`define SCP_INSTR_BITS 16
`define SCP_INSTR_LAST 4'hf
`define SCP_RW_BIT 15
`define SCP_ADDR_W 15
`define SCP_DATA_W 8
`define SCP_DATA_LAST 4'h7
`define SCP_WRAP_ADDR 15'h000

// ****************************************
// configuration vector bit positions
// ****************************************
`define SCP_CFG_MSB 0
`define SCP_CFG_STREAM 1
`define SCP_CFG_UP 2
`define SCP_CFG_FOUR 3
`define SCP_CFG_W 4

// ****************************************
// serial clock limits, host side, and the default register count
// ****************************************
`define SCP_SCLK_MIN_KHZ 1
`define SCP_SCLK_MAX_MHZ 50
`define SCP_REG_COUNT_DEF 64

`endif

// File: scp_pkg.sv
/*
  types shared by the serial control port.
  assumes scp_regs.svh is on the include path.
*/
`default_nettype none

package scp_pkg;

  // ****************************************
  // transaction phase
  // ****************************************
  typedef enum logic [1:0] {
    SCP_INSTR,
    SCP_DATA,
    SCP_DONE
  } scp_phase_t;

endpackage : scp_pkg

`default_nettype wire

// File: scp_serial_port_asserts.sv
/* checker of the serial control port, port level only.
   assumes scp_regs.svh on the include path; bound into scp_serial_port. */
`include "scp_regs.svh"
`default_nettype none
module scp_serial_port_asserts #(
  parameter int REG_COUNT = 64
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // serial link
  input wire logic sclk_i,
  input wire logic cs_b_i,
  input wire logic sdio_i,
  input wire logic sdio_o,
  input wire logic sdio_oe_o,
  input wire logic serial_data_out_o,
  input wire logic serial_data_out_oe_o,
  // configuration
  input wire logic bit_order_select_i,
  input wire logic stream_transfer_enable_i,
  input wire logic address_step_direction_i,
  input wire logic separate_output_line_select_i,
  // write notice and busy flag
  input wire logic reg_write_o,
  input wire logic [`SCP_ADDR_W-1:0] reg_write_addr_o,
  input wire logic [`SCP_DATA_W-1:0] reg_write_data_o,
  input wire logic port_busy_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // link edge counter
  // ****************************************
  logic [4:0] edge_cnt;
  logic [4:0] next_edge_cnt;
  always_comb begin
    next_edge_cnt = (edge_cnt == 5'h1f) ? edge_cnt : edge_cnt + 5'h01;
  end
  always_ff @(posedge sclk_i or posedge cs_b_i or negedge rst_b_i) begin
    if (cs_b_i || !rst_b_i) begin
      edge_cnt <= 5'h00;
    end else begin
      edge_cnt <= next_edge_cnt;
    end
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  a_oe_idle_cs: assert property (cs_b_i |-> !sdio_oe_o && !serial_data_out_oe_o)
    else $error("data pin driven while deselected");
  a_three_wire_sdo: assert property (!separate_output_line_select_i |-> !serial_data_out_oe_o)
    else $error("separate line driven in three-wire mode");
  a_four_wire_sdio: assert property (separate_output_line_select_i |-> !sdio_oe_o)
    else $error("shared line driven in four-wire mode");
  a_busy_drop: assert property ($rose(cs_b_i) |-> ##[1:3] !port_busy_o)
    else $error("busy kept after deselect");
  a_notice_defined: assert property (reg_write_o |-> reg_write_addr_o < REG_COUNT)
    else $error("notice for undefined address");
  a_notice_hold: assert property (!reg_write_o ##1 !reg_write_o |->
    $stable(reg_write_data_o) && $stable(reg_write_addr_o)) else $error("notice fields moved");
  a_no_early_drive: assert property (edge_cnt < 5'h10 |-> !sdio_oe_o && !serial_data_out_oe_o)
    else $error("device drove during instruction");
  a_single_byte: assert property (edge_cnt > 5'h18 && !stream_transfer_enable_i
    |-> !sdio_oe_o && !serial_data_out_oe_o) else $error("drove past one byte");
  a_busy_follow: assert property (!cs_b_i ##1 !cs_b_i ##1 !cs_b_i |-> port_busy_o)
    else $error("busy missing while selected");
  c_notice: cover property (reg_write_o);
  c_stream_read: cover property (stream_transfer_enable_i && sdio_oe_o);
  c_shared_read: cover property (sdio_oe_o);
  c_sep_read: cover property (serial_data_out_oe_o);
endmodule : scp_serial_port_asserts
bind scp_serial_port scp_serial_port_asserts #(.REG_COUNT(REG_COUNT)) chk_u (
  .mclk_i(mclk_i), .rst_b_i(rst_b_i), .sclk_i(sclk_i), .cs_b_i(cs_b_i), .sdio_i(sdio_i),
  .sdio_o(sdio_o), .sdio_oe_o(sdio_oe_o), .serial_data_out_o(serial_data_out_o),
  .serial_data_out_oe_o(serial_data_out_oe_o), .bit_order_select_i(bit_order_select_i),
  .stream_transfer_enable_i(stream_transfer_enable_i),
  .address_step_direction_i(address_step_direction_i),
  .separate_output_line_select_i(separate_output_line_select_i), .reg_write_o(reg_write_o),
  .reg_write_addr_o(reg_write_addr_o), .reg_write_data_o(reg_write_data_o),
  .port_busy_o(port_busy_o));
`default_nettype wire

// File: scp_host.sv
/* host model driving frames on the serial link.
   assumes the bench feeds it the device's data pins and the order and wiring. */
`default_nettype none
module scp_host (
  // order and wiring
  input wire logic msb_i,
  input wire logic four_i,
  // device pins
  input wire logic dev_d_i,
  input wire logic dev_oe_i,
  input wire logic out_d_i,
  input wire logic out_oe_i,
  // link
  output logic sclk_o,
  output logic cs_b_o,
  output logic line_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic hd, hoe, junk;
  // a released line shows a pattern that flips every bit
  assign line_o = hoe ? hd : (dev_oe_i ? dev_d_i : junk);
  initial begin
    sclk_o = 1'b0;
    cs_b_o = 1'b1;
    {hd, hoe, junk} = 3'h0;
  end
  task automatic frame(input logic rd, input logic [14:0] a, input int nbits,
                       input logic [31:0] wd, output logic [31:0] rq);
    logic [15:0] ins;
    int j;
    ins = {rd, a};
    rq = 32'h0;
    cs_b_o = 1'b0;
    #3;
    for (int i = 0; i < 16 + nbits; i++) begin
      j = (i < 16) ? 0 : 8 * ((i - 16) / 8) + (msb_i ? 7 - (i - 16) % 8 : (i - 16) % 8);
      sclk_o = 1'b0;
      junk = ~junk;
      hoe = (i < 16) || !rd;
      hd = (i < 16) ? ins[msb_i ? 15 - i : i] : wd[j];
      #6 sclk_o = 1'b1;
      if (i >= 16 && rd) rq[j] = four_i ? (out_oe_i ? out_d_i : junk) : line_o;
      #6;
    end
    sclk_o = 1'b0;
    hoe = 1'b0;
    #6 cs_b_o = 1'b1;
    #20;
  endtask : frame
endmodule : scp_host
`default_nettype wire

// File: scp_serial_port_test.sv
/* self-checking bench of the serial control port.
   assumes scp_host and the checker are compiled alongside. */
`default_nettype none
module scp_serial_port_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RC = 16;
  logic mclk_i, rst_b_i, sclk, cs_b, line, msb, strm, up, four;
  logic sd, sd_oe, so, so_oe, wr_p, busy;
  logic [14:0] wa;
  logic [7:0] wd;
  logic [31:0] rq;
  logic [22:0] notes[$];
  int num_errors, check_count, cycles;
  scp_serial_port #(.REG_COUNT(RC)) dut_u (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .sclk_i(sclk),
    .cs_b_i(cs_b), .sdio_i(line), .sdio_o(sd), .sdio_oe_o(sd_oe), .serial_data_out_o(so),
    .serial_data_out_oe_o(so_oe), .bit_order_select_i(msb), .stream_transfer_enable_i(strm),
    .address_step_direction_i(up), .separate_output_line_select_i(four), .reg_write_o(wr_p),
    .reg_write_addr_o(wa), .reg_write_data_o(wd), .port_busy_o(busy));
  scp_host host_u (.msb_i(msb), .four_i(four), .dev_d_i(sd), .dev_oe_i(sd_oe), .out_d_i(so),
    .out_oe_i(so_oe), .sclk_o(sclk), .cs_b_o(cs_b), .line_o(line));
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cycles++;
    if (wr_p === 1'b1) notes.push_back({wa, wd});
    if (cycles == 5000) begin
      num_errors++;
      print_verdict();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // a throwaway write to an undefined place lets the order and wiring settle
  task automatic setcfg(input logic m, input logic s, input logic u, input logic f);
    @(posedge mclk_i);
    {msb, strm, up, four} <= {m, s, u, f};
    @(posedge mclk_i);
    host_u.frame(1'b0, 15'h7ffe, 8, 32'h0, rq);
  endtask : setcfg
  task automatic wr(input logic [14:0] a, input int nb, input int n, input logic [31:0] d);
    notes = {};
    host_u.frame(1'b0, a, nb, d, rq);
    repeat (12) @(posedge mclk_i);
    check("notices", 32'(notes.size()), 32'(n));
    for (int i = 0; i < n && i < notes.size(); i++) begin
      check("notice", {9'h0, notes[i]}, {9'h0, a, d[8*i +: 8]});
      a = (a >= 15'(RC - 1)) ? 15'h000 : a + 15'h001;
    end
  endtask : wr
  task automatic rd(input logic [14:0] a, input int nb, input logic [31:0] e);
    host_u.frame(1'b1, a, nb, 32'h0, rq);
    check("read", rq, e);
  endtask : rd
  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict
  initial begin
    {rst_b_i, msb, strm, up, four} <= 5'h00;
    {num_errors, check_count, cycles} = '0;
    repeat (16) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    setcfg(1'b1, 1'b0, 1'b1, 1'b1);
    wr(15'h00a, 8, 1, 32'h55);
    rd(15'h00a, 8, 32'h55);
    wr(15'h003, 16, 1, 32'h6611);
    // once the device lets go, the host sees its line flip bit by bit
    rd(15'h004, 16, 32'haa00);
    wr(15'h100, 8, 0, 32'haa);
    rd(15'h100, 8, 32'h0);
    setcfg(1'b0, 1'b1, 1'b1, 1'b0);
    wr(15'(RC - 2), 32, 4, 32'h04030201);
    rd(15'(RC - 2), 32, 32'h04030201);
    setcfg(1'b1, 1'b1, 1'b0, 1'b1);
    rd(15'h001, 24, 32'h020304);
    wr(15'h005, 12, 1, 32'hf77);
    rd(15'h004, 8, 32'h0);
    print_verdict();
  end
endmodule : scp_serial_port_test
`default_nettype wire
